// ==== inc/card_prop_cfg.svh ====
// card_prop_cfg.svh: constants for the card property field decoder
// assumes inclusion by bare name; definitions only
`ifndef CARD_PROP_CFG_SVH
`define CARD_PROP_CFG_SVH

// ------------------------------------------------------------
// field widths
// ------------------------------------------------------------
`define CP_GRP_CODE_W 5
`define CP_BLEN_CODE_W 4
`define CP_SPEED_W 3
`define CP_ECC_W 2
`define CP_FMT_W 2
`define CP_CLASS_W 12
`define CP_CRC_W 7

// ------------------------------------------------------------
// encodings and limits
// ------------------------------------------------------------
`define CP_BLEN_MAX_CODE 4'hb
`define CP_ECC_NONE 2'h0
`define CP_ECC_BCH 2'h1
`define CP_ECC_BCH_BITS 2'h3
`define CP_FMT_GRP_STD 1'h0
`define CP_FMT_PARTITIONED 2'h0
`define CP_FMT_FLOPPY 2'h1
`define CP_FMT_UNIVERSAL 2'h2
`define CP_FMT_OTHER 2'h3

// ------------------------------------------------------------
// command class ranges
// ------------------------------------------------------------
`define CP_CLASS_ALL 12'h3ff
`define CP_CLASS_ERASE 12'h1e0
`define CP_CLASS_PROTECT 12'h1c0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CP_RST_COPY 1'h0
`define CP_RST_PERM 1'h0
`define CP_RST_TEMP 1'h0

`endif

// ==== inc/card_prop_pkg.sv ====
// card_prop_pkg: types for the card property field decoder
// assumes card_prop_cfg.svh is on the include path
`include "card_prop_cfg.svh"

package card_prop_pkg;

    // factory image of the descriptor's latter fields
    typedef struct packed {
        logic [`CP_GRP_CODE_W-1:0] eraseGroupSizeCode;
        logic [`CP_GRP_CODE_W-1:0] eraseGroupMultiplierCode;
        logic [`CP_GRP_CODE_W-1:0] protectGroupSizeCode;
        logic protectGroupEnable;
        logic [`CP_ECC_W-1:0] recommendedCorrection;
        logic [`CP_SPEED_W-1:0] writeSpeedFactor;
        logic [`CP_BLEN_CODE_W-1:0] writeBlockLengthCode;
        logic writePartialAllowed;
        logic contentProtectSupport;
        logic [`CP_CLASS_W-1:0] classSupportMask;
        logic [`CP_CRC_W-1:0] factoryCrc;
    } factory_fields_t;

    // host-rewritable fields
    typedef struct packed {
        logic fileFormatGroup;
        logic copyFlag;
        logic permanentProtect;
        logic temporaryProtect;
        logic [`CP_FMT_W-1:0] fileFormat;
        logic [`CP_ECC_W-1:0] storedCorrection;
        logic [`CP_CRC_W-1:0] crc;
    } settable_fields_t;

    // decoded file format
    typedef enum logic [2:0] {
        FMT_PARTITIONED,
        FMT_FLOPPY,
        FMT_UNIVERSAL,
        FMT_OTHER,
        FMT_RESERVED
    } file_format_t;

    // write/erase command offered to the gate
    typedef struct packed {
        logic isErase;
        logic [11:0] byteLen;
        logic [3:0] cmdClass;
    } wr_cmd_t;

endpackage : card_prop_pkg

// ==== rtl/card_size_calc.sv ====
// card_size_calc: registered erase-unit and protect-group sizing
// assumes inputs stable or updated synchronously to core_clk
`timescale 1ns/1ps
`include "card_prop_cfg.svh"

module card_size_calc #(
    parameter int CODE_W = `CP_GRP_CODE_W
) (
    input wire logic core_clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [CODE_W-1:0] sizeCode, // erase group size code
    input wire logic [CODE_W-1:0] multCode, // erase group multiplier code
    input wire logic [CODE_W-1:0] wpCode, // protect group size code
    output logic [2*CODE_W+1:0] eraseUnit_r, // write blocks per erase unit
    output logic [CODE_W:0] wpGroups_r // erase groups per protect group
);
    // refuse code widths the sizing logic cannot serve
    if (CODE_W < 1 || CODE_W > 15)
    begin : badCodeW
        $error("card_size_calc: CODE_W out of range");
    end

    // ------------------------------------------------------------
    // size products
    // ------------------------------------------------------------
    logic [CODE_W:0] sizeP1;
    logic [CODE_W:0] multP1;
    assign sizeP1 = {1'b0, sizeCode} + {{CODE_W{1'b0}}, 1'b1};
    assign multP1 = {1'b0, multCode} + {{CODE_W{1'b0}}, 1'b1};

    // erase unit register
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            eraseUnit_r <= '0;
        else
            eraseUnit_r <= sizeP1 * multP1;
    end

    // protect group register
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            wpGroups_r <= '0;
        else
            wpGroups_r <= {1'b0, wpCode} + {{CODE_W{1'b0}}, 1'b1};
    end
endmodule : card_size_calc

// ==== rtl/card_blen_decode.sv ====
// card_blen_decode: block length code to byte count, registered
// assumes code presented synchronously to core_clk
`timescale 1ns/1ps
`include "card_prop_cfg.svh"

module card_blen_decode (
    input wire logic core_clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [`CP_BLEN_CODE_W-1:0] code, // block length code
    output logic [11:0] bytes_r, // block length in bytes, zero if reserved
    output logic reserved_r // code is reserved
);
    logic isRes;
    assign isRes = code > `CP_BLEN_MAX_CODE;

    // length decode, 2^n bytes
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bytes_r <= 12'h000;
            reserved_r <= 1'b0;
        end
        else
        begin
            bytes_r <= isRes ? 12'h000 : (12'h001 << code);
            reserved_r <= isRes;
        end
    end
endmodule : card_blen_decode

// ==== rtl/card_property_field_decode.sv ====
// card_property_field_decode: latter descriptor fields, decode and write gate
// assumes factory image is static and host controls arrive as one-cycle pulses
`timescale 1ns/1ps
`include "card_prop_cfg.svh"

module card_property_field_decode #(
    parameter bit ROM_CARD = 1'b0,
    parameter bit CONTENT_PROT_IMPL = 1'b1
) (
    input wire logic core_clk, // system clock, 20 MHz
    input wire logic rstn, // async reset, active low
    input wire card_prop_pkg::factory_fields_t factory, // factory image
    input wire logic hostWrite, // host rewrites settable fields, pulse
    input wire card_prop_pkg::settable_fields_t hostData, // new settable values
    input wire logic cmdValid, // write/erase command offered, pulse
    input wire card_prop_pkg::wr_cmd_t cmd, // command details
    output card_prop_pkg::settable_fields_t settable_r, // current settable fields
    output logic [11:0] eraseUnit_r, // write blocks per erase unit
    output logic [5:0] wpGroups_r, // erase groups per protect group
    output logic groupProtectAvail_r, // group protection offered
    output logic [7:0] writeSpeedMult_r, // program time multiple of read
    output logic [11:0] writeBlockBytes_r, // write block length in bytes
    output logic writeBlockReserved_r, // write length code reserved
    output logic [11:0] minWriteBytes_r, // shortest accepted write block
    output logic contentProtect_r, // content protection supported
    output card_prop_pkg::file_format_t fileFormatDec_r, // decoded file format
    output logic [1:0] eccBits_r, // correctable bits per block
    output logic eccReserved_r, // stored correction code reserved
    output logic recEccReserved_r, // recommended code reserved
    output logic crcMatchesFactory_r, // checksum equals factory value
    output logic [11:0] eraseClasses_r, // classes hit by erase group size
    output logic [11:0] protectClasses_r, // classes hit by protect fields
    output logic [11:0] globalClasses_r, // classes hit by copy/protect/crc
    output logic writeProtected_r, // whole card write protected
    output logic cmdDone_r, // command answered, pulse
    output logic cmdAccepted_r, // command may proceed
    output logic cmdRefused_r // command refused, memory untouched
);
    // ------------------------------------------------------------
    // sizing submodules
    // ------------------------------------------------------------
    logic [11:0] writeBytes;
    logic writeRes;
    logic [11:0] eraseUnitW;
    logic [5:0] wpGroupsW;

    card_size_calc #(.CODE_W(`CP_GRP_CODE_W)) sizeCalc (
        .core_clk(core_clk),
        .rstn(rstn),
        .sizeCode(factory.eraseGroupSizeCode),
        .multCode(factory.eraseGroupMultiplierCode),
        .wpCode(factory.protectGroupSizeCode),
        .eraseUnit_r(eraseUnitW),
        .wpGroups_r(wpGroupsW)
    );

    card_blen_decode blenDec (
        .core_clk(core_clk),
        .rstn(rstn),
        .code(factory.writeBlockLengthCode),
        .bytes_r(writeBytes),
        .reserved_r(writeRes)
    );

    assign eraseUnit_r = eraseUnitW;
    assign wpGroups_r = wpGroupsW;
    assign writeBlockBytes_r = writeBytes;
    assign writeBlockReserved_r = writeRes;

    // ------------------------------------------------------------
    // settable fields
    // ------------------------------------------------------------
    logic crcLoaded_r;

    // copy and protect bits; copy and permanent only ever set
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            settable_r.copyFlag <= `CP_RST_COPY;
            settable_r.permanentProtect <= `CP_RST_PERM;
            settable_r.temporaryProtect <= `CP_RST_TEMP;
        end
        else if (hostWrite)
        begin
            settable_r.copyFlag <= settable_r.copyFlag | hostData.copyFlag;
            settable_r.permanentProtect <= settable_r.permanentProtect
                | hostData.permanentProtect;
            settable_r.temporaryProtect <= hostData.temporaryProtect;
        end
    end

    // file format fields, frozen on a ROM card
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            settable_r.fileFormatGroup <= `CP_FMT_GRP_STD;
            settable_r.fileFormat <= `CP_FMT_PARTITIONED;
        end
        else if (hostWrite && !ROM_CARD)
        begin
            settable_r.fileFormatGroup <= hostData.fileFormatGroup;
            settable_r.fileFormat <= hostData.fileFormat;
        end
    end

    // stored correction code, default none
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            settable_r.storedCorrection <= `CP_ECC_NONE;
        else if (hostWrite)
            settable_r.storedCorrection <= hostData.storedCorrection;
    end

    // checksum: factory value after reset, host value once rewritten
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            settable_r.crc <= '0;
            crcLoaded_r <= 1'b0;
        end
        else if (hostWrite)
        begin
            settable_r.crc <= hostData.crc;
            crcLoaded_r <= 1'b1;
        end
        else if (!crcLoaded_r)
        begin
            settable_r.crc <= factory.factoryCrc;
            crcLoaded_r <= 1'b1;
        end
    end

    // checksum comparison
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            crcMatchesFactory_r <= 1'b0;
        else
            crcMatchesFactory_r <= crcLoaded_r
                && (settable_r.crc == factory.factoryCrc);
    end

    // ------------------------------------------------------------
    // factory field decode
    // ------------------------------------------------------------
    // group protection, speed, partial length, content protection
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            groupProtectAvail_r <= 1'b0;
            writeSpeedMult_r <= 8'h00;
            minWriteBytes_r <= 12'h000;
            contentProtect_r <= 1'b0;
        end
        else
        begin
            groupProtectAvail_r <= factory.protectGroupEnable;
            writeSpeedMult_r <= 8'h01 << factory.writeSpeedFactor;
            minWriteBytes_r <= factory.writePartialAllowed ? 12'h001 : writeBytes;
            contentProtect_r <= CONTENT_PROT_IMPL
                & factory.contentProtectSupport;
        end
    end

    // file format decode
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            fileFormatDec_r <= card_prop_pkg::FMT_PARTITIONED;
        else if (settable_r.fileFormatGroup != `CP_FMT_GRP_STD)
            fileFormatDec_r <= card_prop_pkg::FMT_RESERVED;
        else
        begin
            unique case (settable_r.fileFormat)
                `CP_FMT_PARTITIONED: fileFormatDec_r <= card_prop_pkg::FMT_PARTITIONED;
                `CP_FMT_FLOPPY: fileFormatDec_r <= card_prop_pkg::FMT_FLOPPY;
                `CP_FMT_UNIVERSAL: fileFormatDec_r <= card_prop_pkg::FMT_UNIVERSAL;
                `CP_FMT_OTHER: fileFormatDec_r <= card_prop_pkg::FMT_OTHER;
            endcase
        end
    end

    // correction code decode
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            eccBits_r <= 2'h0;
            eccReserved_r <= 1'b0;
            recEccReserved_r <= 1'b0;
        end
        else
        begin
            eccBits_r <= (settable_r.storedCorrection == `CP_ECC_BCH)
                ? `CP_ECC_BCH_BITS : 2'h0;
            eccReserved_r <= settable_r.storedCorrection[1];
            recEccReserved_r <= factory.recommendedCorrection[1];
        end
    end

    // ------------------------------------------------------------
    // command class map
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            eraseClasses_r <= 12'h000;
            protectClasses_r <= 12'h000;
            globalClasses_r <= 12'h000;
        end
        else
        begin
            eraseClasses_r <= `CP_CLASS_ERASE;
            protectClasses_r <= factory.protectGroupEnable
                ? `CP_CLASS_PROTECT : 12'h000;
            globalClasses_r <= `CP_CLASS_ALL;
        end
    end

    // ------------------------------------------------------------
    // write and erase gate
    // ------------------------------------------------------------
    logic prot;
    logic lenBad;
    assign prot = settable_r.permanentProtect | settable_r.temporaryProtect;
    assign lenBad = !cmd.isErase && (writeRes || cmd.byteLen == 12'h000
        || cmd.byteLen > writeBytes
        || (!factory.writePartialAllowed && cmd.byteLen != writeBytes));

    // protection level seen outside
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            writeProtected_r <= 1'b0;
        else
            writeProtected_r <= prot;
    end

    // one-cycle answer to each offered command
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmdDone_r <= 1'b0;
            cmdAccepted_r <= 1'b0;
            cmdRefused_r <= 1'b0;
        end
        else
        begin
            cmdDone_r <= cmdValid;
            cmdAccepted_r <= cmdValid && !prot && !lenBad;
            cmdRefused_r <= cmdValid && (prot || lenBad);
        end
    end
endmodule : card_property_field_decode

// ==== sim/card_property_field_decode_chk.sv ====
// card_property_field_decode_chk: port-level checks on the field decoder
// assumes bound to card_property_field_decode; factory image static between changes
`timescale 1ns/1ps

module card_property_field_decode_chk (
    input wire logic core_clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire card_prop_pkg::factory_fields_t factory, // factory image
    input wire logic cmdValid, // command offered
    input wire card_prop_pkg::settable_fields_t settable_r, // settable fields
    input wire logic [11:0] eraseUnit_r, // erase unit
    input wire logic [5:0] wpGroups_r, // protect group span
    input wire logic [11:0] protectClasses_r, // protect classes
    input wire logic [7:0] writeSpeedMult_r, // speed multiple
    input wire logic [11:0] writeBlockBytes_r, // write block bytes
    input wire logic cmdDone_r, // answer pulse
    input wire logic cmdAccepted_r, // accepted
    input wire logic cmdRefused_r // refused
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic [1:0] stableCnt_r; // edges the factory image has held
    card_prop_pkg::factory_fields_t factPrev_r; // last factory image
    // count edges since the factory image last changed
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stableCnt_r <= 2'h0;
            factPrev_r <= '0;
        end
        else
        begin
            factPrev_r <= factory;
            if (factory != factPrev_r)
                stableCnt_r <= 2'h0;
            else if (stableCnt_r != 2'h3)
                stableCnt_r <= stableCnt_r + 2'h1;
        end
    end

    // image held for three edges and not changed since the last one
    logic steady;
    assign steady = (stableCnt_r == 2'h3) && (factory == factPrev_r);

    chk_erase_unit: assert property (steady |-> eraseUnit_r ==
        (12'(factory.eraseGroupSizeCode) + 12'h1) * (12'(factory.eraseGroupMultiplierCode) + 12'h1))
        else $error("erase unit size wrong");
    chk_protect_span: assert property (steady |->
        wpGroups_r == 6'(factory.protectGroupSizeCode) + 6'h1) else $error("protect span wrong");
    chk_protect_classes: assert property (steady |->
        protectClasses_r == (factory.protectGroupEnable ? 12'h1c0 : 12'h000))
        else $error("protect classes wrong");
    chk_speed_mult: assert property (steady |->
        writeSpeedMult_r == 8'h01 << factory.writeSpeedFactor) else $error("speed multiple wrong");
    chk_block_bytes: assert property (steady |-> writeBlockBytes_r ==
        (factory.writeBlockLengthCode < 4'hc ? 12'h001 << factory.writeBlockLengthCode : 12'h000))
        else $error("block length wrong");
    chk_copy_sticky: assert property (settable_r.copyFlag |=> settable_r.copyFlag)
        else $error("copy flag cleared");
    chk_perm_sticky: assert property (
        settable_r.permanentProtect |=> settable_r.permanentProtect) else $error("perm cleared");
    chk_cmd_answer: assert property (cmdValid |=> cmdDone_r && (cmdAccepted_r != cmdRefused_r))
        else $error("command answer wrong");
    chk_protect_refuse: assert property (cmdValid &&
        (settable_r.permanentProtect || settable_r.temporaryProtect) |=> cmdRefused_r)
        else $error("protected command not refused");
endmodule : card_property_field_decode_chk

bind card_property_field_decode card_property_field_decode_chk chk_i (
    .core_clk(core_clk), .rstn(rstn), .factory(factory), .cmdValid(cmdValid),
    .settable_r(settable_r), .eraseUnit_r(eraseUnit_r), .wpGroups_r(wpGroups_r),
    .protectClasses_r(protectClasses_r), .writeSpeedMult_r(writeSpeedMult_r),
    .writeBlockBytes_r(writeBlockBytes_r), .cmdDone_r(cmdDone_r),
    .cmdAccepted_r(cmdAccepted_r), .cmdRefused_r(cmdRefused_r));

// ==== sim/host_model.sv ====
// host_model: card bus host, rewrites settable fields and offers write/erase commands
// assumes tb_top steps it through its tasks, one request at a time
`timescale 1ns/1ps

module host_model (
    input wire logic core_clk, // system clock
    input wire logic cmdDone_r, // answer pulse
    input wire logic cmdAccepted_r, // accepted
    input wire logic cmdRefused_r, // refused
    output card_prop_pkg::settable_fields_t hostData, // new settable values
    output logic hostWrite, // rewrite pulse
    output logic cmdValid, // command pulse
    output card_prop_pkg::wr_cmd_t cmd // command details
);
    // idle bus at time zero
    initial
    begin
        hostWrite = 1'b0;
        cmdValid = 1'b0;
        hostData = '0;
        cmd = '0;
    end

    // one-cycle rewrite; data turned over once released
    task automatic writeFields(input card_prop_pkg::settable_fields_t d);
        card_prop_pkg::settable_fields_t w;
        w = d;
        w.crc = 7'h2b ^ {d.fileFormat, d.storedCorrection, d.copyFlag, d.permanentProtect,
            d.temporaryProtect};
        @(posedge core_clk);
        #1;
        hostWrite = 1'b1;
        hostData = w;
        @(posedge core_clk);
        #1;
        hostWrite = 1'b0;
        hostData = ~w;
    endtask : writeFields

    // one-cycle command; answer read the cycle after it is taken
    task automatic sendCmd(input logic erase, input logic [11:0] len, output logic acc,
        output logic refd);
        @(posedge core_clk);
        #1;
        cmdValid = 1'b1;
        cmd = '{isErase: erase, byteLen: len, cmdClass: 4'h4};
        @(posedge core_clk);
        #1;
        cmdValid = 1'b0;
        cmd = ~cmd;
        acc = cmdAccepted_r & cmdDone_r;
        refd = cmdRefused_r & cmdDone_r;
    endtask : sendCmd
endmodule : host_model

// ==== sim/tb_top.sv ====
// tb_top: self-checking bench for the card property field decoder
// assumes host_model and the bound checker are compiled alongside
`timescale 1ns/1ps

`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin \
    miscompares++; $display("ERROR %0t value mismatch", $time); end end

module tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    int miscompares = 0;
    int checksDone = 0;
    card_prop_pkg::factory_fields_t factory = '0;
    card_prop_pkg::settable_fields_t hostData, settable_r, sd;
    card_prop_pkg::wr_cmd_t cmd;
    card_prop_pkg::file_format_t fileFormatDec_r, ef;
    logic hostWrite, cmdValid, acc, refd, groupProtectAvail_r, writeBlockReserved_r;
    logic contentProtect_r, eccReserved_r, recEccReserved_r, crcMatchesFactory_r;
    logic writeProtected_r, cmdDone_r, cmdAccepted_r, cmdRefused_r;
    logic [11:0] eraseUnit_r, writeBlockBytes_r, minWriteBytes_r, eraseClasses_r;
    logic [11:0] protectClasses_r, globalClasses_r;
    logic [7:0] writeSpeedMult_r;
    logic [5:0] wpGroups_r;
    logic [1:0] eccBits_r;

    always #25 core_clk = ~core_clk;

    card_property_field_decode card_property_field_decode_i (.core_clk(core_clk), .rstn(rstn),
        .factory(factory), .hostWrite(hostWrite), .hostData(hostData), .cmdValid(cmdValid),
        .cmd(cmd), .settable_r(settable_r), .eraseUnit_r(eraseUnit_r), .wpGroups_r(wpGroups_r),
        .groupProtectAvail_r(groupProtectAvail_r), .writeSpeedMult_r(writeSpeedMult_r),
        .writeBlockBytes_r(writeBlockBytes_r), .writeBlockReserved_r(writeBlockReserved_r),
        .minWriteBytes_r(minWriteBytes_r), .contentProtect_r(contentProtect_r),
        .fileFormatDec_r(fileFormatDec_r), .eccBits_r(eccBits_r), .eccReserved_r(eccReserved_r),
        .recEccReserved_r(recEccReserved_r), .crcMatchesFactory_r(crcMatchesFactory_r),
        .eraseClasses_r(eraseClasses_r), .protectClasses_r(protectClasses_r),
        .globalClasses_r(globalClasses_r), .writeProtected_r(writeProtected_r),
        .cmdDone_r(cmdDone_r), .cmdAccepted_r(cmdAccepted_r), .cmdRefused_r(cmdRefused_r));

    host_model host_model_i (.core_clk(core_clk), .cmdDone_r(cmdDone_r),
        .cmdAccepted_r(cmdAccepted_r), .cmdRefused_r(cmdRefused_r), .hostData(hostData),
        .hostWrite(hostWrite), .cmdValid(cmdValid), .cmd(cmd));

    task automatic stopTest;
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stopTest

    // new factory image, then let the decode pipeline settle
    task automatic setFactory(input card_prop_pkg::factory_fields_t f);
        @(posedge core_clk);
        #1;
        factory = f;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : setFactory

    task automatic runCmd(input logic erase, input logic [11:0] len, input logic expAcc);
        host_model_i.sendCmd(erase, len, acc, refd);
        `CHK(acc, expAcc);
        `CHK(refd, !expAcc);
    endtask : runCmd

    task automatic testReset;
        `CHK(settable_r.copyFlag, 1'b0);
        `CHK(settable_r.permanentProtect, 1'b0);
        `CHK(settable_r.temporaryProtect, 1'b0);
        `CHK(settable_r.crc, factory.factoryCrc);
        `CHK(crcMatchesFactory_r, 1'b1);
        $display("reset defaults done");
    endtask : testReset

    task automatic testDecode;
        card_prop_pkg::factory_fields_t f;
        logic [11:0] blen;
        for (int n = 0; n < 16; n++)
        begin
            f = factory;
            f.writeSpeedFactor = n[2:0];
            f.writeBlockLengthCode = n[3:0];
            f.writePartialAllowed = n[0];
            f.contentProtectSupport = n[1];
            f.recommendedCorrection = n[1:0];
            f.eraseGroupSizeCode = 5'(n * 2);
            f.eraseGroupMultiplierCode = 5'(31 - n);
            f.protectGroupSizeCode = 5'(n * 2 + 1);
            f.protectGroupEnable = n[2];
            setFactory(f);
            blen = (n < 12) ? 12'h001 << n : 12'h000;
            `CHK(eraseUnit_r, 12'((n * 2 + 1) * (32 - n)));
            `CHK(wpGroups_r, 6'(n * 2 + 2));
            `CHK(groupProtectAvail_r, n[2]);
            `CHK(protectClasses_r, n[2] ? 12'h1c0 : 12'h000);
            `CHK(writeSpeedMult_r, 8'h01 << n[2:0]);
            `CHK(writeBlockBytes_r, blen);
            `CHK(writeBlockReserved_r, n > 11);
            `CHK(minWriteBytes_r, n[0] ? 12'h001 : blen);
            `CHK(contentProtect_r, n[1]);
            `CHK(recEccReserved_r, n[1]);
            `CHK(eraseClasses_r, 12'h1e0);
            `CHK(globalClasses_r, 12'h3ff);
        end
        $display("factory decode done");
    endtask : testDecode

    task automatic testFormat;
        for (int i = 0; i < 8; i++)
        begin
            sd = '0;
            sd.fileFormatGroup = i[2];
            sd.fileFormat = i[1:0];
            sd.storedCorrection = i[1:0];
            host_model_i.writeFields(sd);
            repeat (2) @(posedge core_clk);
            #1;
            ef = i[2] ? card_prop_pkg::FMT_RESERVED : card_prop_pkg::file_format_t'(i[1:0]);
            `CHK(fileFormatDec_r, ef);
            `CHK(eccBits_r, (i[1:0] == 2'h1) ? 2'h3 : 2'h0);
            `CHK(eccReserved_r, i[1]);
        end
        $display("format and correction done");
    endtask : testFormat

    task automatic testCmds;
        card_prop_pkg::factory_fields_t f;
        f = factory;
        f.writeBlockLengthCode = 4'h9;
        f.writePartialAllowed = 1'b0;
        setFactory(f);
        runCmd(1'b0, 12'h200, 1'b1);
        runCmd(1'b0, 12'h1ff, 1'b0);
        runCmd(1'b1, 12'h000, 1'b1);
        f.writeBlockLengthCode = 4'hc;
        f.writePartialAllowed = 1'b1;
        setFactory(f);
        runCmd(1'b0, 12'h001, 1'b0);
        f.writeBlockLengthCode = 4'h9;
        setFactory(f);
        runCmd(1'b0, 12'h001, 1'b1);
        runCmd(1'b0, 12'h201, 1'b0);
        runCmd(1'b0, 12'h000, 1'b0);
        $display("command gate done");
    endtask : testCmds

    task automatic testProtect;
        sd = '0;
        sd.temporaryProtect = 1'b1;
        host_model_i.writeFields(sd);
        runCmd(1'b0, 12'h001, 1'b0);
        runCmd(1'b1, 12'h000, 1'b0);
        `CHK(writeProtected_r, 1'b1);
        sd.temporaryProtect = 1'b0;
        host_model_i.writeFields(sd);
        runCmd(1'b0, 12'h001, 1'b1);
        `CHK(writeProtected_r, 1'b0);
        sd.copyFlag = 1'b1;
        sd.permanentProtect = 1'b1;
        host_model_i.writeFields(sd);
        host_model_i.writeFields('0);
        runCmd(1'b1, 12'h000, 1'b0);
        runCmd(1'b0, 12'h001, 1'b0);
        `CHK(settable_r.copyFlag, 1'b1);
        `CHK(settable_r.permanentProtect, 1'b1);
        `CHK(crcMatchesFactory_r, 1'b0);
        $display("protection done");
    endtask : testProtect

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        stopTest();
    end

    // main sequence
    initial
    begin
        factory.factoryCrc = 7'h11;
        factory.writeBlockLengthCode = 4'h9;
        repeat (10) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        testReset();
        testDecode();
        testFormat();
        testCmds();
        testProtect();
        stopTest();
    end
endmodule : tb_top
